// ---- include/rmps_pkg.sv ----
// constants and types shared by the radio mode and power sequencer
package rmps_pkg;

	// register offsets on the host register port
	localparam logic [7:0] ADDR_PWRUP = 8'h2C; // power-up timing control
	localparam logic [7:0] ADDR_ACTION = 8'h2D; // event action control
	localparam logic [7:0] ADDR_MODE = 8'h2E; // mode and power override

	// field positions
	localparam int PU_SEL_BIT = 4; // powerup_timing_select
	localparam int PU_CODE_LSB = 0; // powerup_timeout_code
	localparam int ACT_TERM_BIT = 7; // rx_timeout_action
	localparam int ACT_UNLOCK_BIT = 5; // rx_unlock_action
	localparam int ACT_BAD_BIT = 4; // rx_bad_packet_action
	localparam int ACT_GOOD_BIT = 3; // rx_good_packet_action
	localparam int ACT_TXD_LSB = 0; // tx_done_action
	localparam int MODE_LSB = 5; // radio_mode_select
	localparam int OVR_LSB = 2; // power override
	localparam int TXF_BIT = 1; // tx_fifo_in_use
	localparam int RXF_BIT = 0; // rx_fifo_in_use

	// reset values and override codes
	localparam logic [3:0] PU_CODE_RST = 4'hA; // 6 ms
	localparam logic [2:0] OVR_RST = 3'h3;
	localparam logic [2:0] OVR_AFTER_TXW = 3'h3; // code 1 turns into this
	localparam logic [2:0] OVR_FORCE_DX = 3'h1; // force supply and xtal

	// radio modes
	typedef enum logic [2:0] {
		MODE_STOP_TX = 3'h0,
		MODE_STOP_RX = 3'h1,
		MODE_TX = 3'h2,
		MODE_RX = 3'h3,
		MODE_CAL_TX_STOP = 3'h4,
		MODE_CAL_RX_STOP = 3'h5,
		MODE_CAL_RX_RX = 3'h6
	} rmps_mode_t;

	// detail codes reported in the stopped modes
	localparam logic [2:0] INFO_OK = 3'h0;
	localparam logic [2:0] INFO_PWRUP_TO = 3'h1;
	localparam logic [2:0] INFO_UNLOCK = 3'h2;
	localparam logic [2:0] INFO_TERM = 3'h4;
	localparam logic [2:0] INFO_BAD_LEN = 3'h5;
	localparam logic [2:0] INFO_BAD_ADDR = 3'h6;
	localparam logic [2:0] INFO_BAD_CRC = 3'h7;

	// tx completion actions
	localparam logic [1:0] TXA_STOP = 2'h0;
	localparam logic [1:0] TXA_RECAL_TX = 2'h1;
	localparam logic [1:0] TXA_RX = 2'h2;
	localparam logic [1:0] TXA_CAL_RX = 2'h3;

	// sequencer states
	typedef enum logic [2:0] {
		S_STOP = 3'b000,
		S_PWRUP = 3'b001,
		S_CAL = 3'b010,
		S_TX = 3'b011,
		S_RX = 3'b100
	} rmps_state_t;

	// where to go once calibration finishes
	typedef enum logic [1:0] {
		AFT_STOP_TX = 2'b00,
		AFT_STOP_RX = 2'b01,
		AFT_TX = 2'b10,
		AFT_RX = 2'b11
	} rmps_after_t;

	// timing: all power-up timeouts are whole multiples of the tick
	localparam int CLK_KHZ = 50000; // 50 MHz system clock
	localparam int TICK_US = 50; // timeout tick in microseconds
	localparam int TICK_CYC = TICK_US * CLK_KHZ / 1000; // 2500 cycles
	localparam int unsigned PU_US [16] = '{200, 250, 400, 500, 750, 1000,
		1500, 2000, 3000, 4000, 6000, 8000, 12000, 16000, 24000, 32000};

	// timeout code to tick count
	function automatic logic [9:0] rmps_pu_ticks(input logic [3:0] code);
		return 10'(PU_US[code] / TICK_US);
	endfunction : rmps_pu_ticks

endpackage : rmps_pkg

// ---- src/rmps_sync.sv ----
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module rmps_sync #(
	parameter int W = 1 // number of bits
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic [W-1:0] d, // asynchronous levels
	output logic [W-1:0] q // synchronised levels
);
	logic [W-1:0] meta_reg; // first stage, read only by second
	logic [W-1:0] meta_next; // first stage next
	logic [W-1:0] q_reg; // second stage
	logic [W-1:0] q_next; // second stage next

	// next values of both stages
	always_comb begin
		meta_next = d;
		q_next = meta_reg;
	end

	// register both stages
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			q_reg <= q_next;
		end
	end

	assign q = q_reg;
endmodule : rmps_sync

// ---- src/rmps_timer.sv ----
// power-up timeout timer with a 50 us tick prescaler
`timescale 1ns/100ps
module rmps_timer
	import rmps_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic start, // one-cycle pulse, loads ticks
	input wire logic [9:0] ticks, // timeout length in ticks
	output logic expired // level, held until next start
);
	logic [11:0] pre_reg; // prescaler count
	logic [11:0] pre_next;
	logic [9:0] cnt_reg; // ticks left
	logic [9:0] cnt_next;
	logic run_reg; // timer running
	logic run_next;
	logic exp_reg; // timeout reached
	logic exp_next;
	logic tick; // one-cycle tick enable

	assign tick = (pre_reg == 12'(TICK_CYC - 1));

	// prescaler and down counter
	always_comb begin
		pre_next = tick ? 12'h000 : pre_reg + 12'h001;
		cnt_next = cnt_reg;
		run_next = run_reg;
		exp_next = exp_reg;
		if (start) begin // restart from a clean tick
			pre_next = 12'h000;
			cnt_next = ticks;
			run_next = 1'b1;
			exp_next = 1'b0;
		end else if (run_reg && tick) begin // one tick gone
			cnt_next = cnt_reg - 10'h001;
			if (cnt_reg == 10'h001) begin
				run_next = 1'b0;
				exp_next = 1'b1;
			end
		end
	end

	// register timer state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_reg <= 12'h000;
			cnt_reg <= 10'h000;
			run_reg <= 1'b0;
			exp_reg <= 1'b0;
		end else begin
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
			run_reg <= run_next;
			exp_reg <= exp_next;
		end
	end

	assign expired = exp_reg;
endmodule : rmps_timer

// ---- src/rmps_top.sv ----
// radio mode and power sequencer with its three control registers
`timescale 1ns/100ps
module rmps_top
	import rmps_pkg::*;
(
	input wire logic clk, // 50 MHz system clock
	input wire logic rst, // async reset, active high
	input wire logic reg_wr_en, // register write strobe
	input wire logic [7:0] reg_addr, // register offset
	input wire logic [7:0] reg_wdata, // write data
	output logic [7:0] reg_rdata, // read data, one cycle late
	input wire logic pwrup_done_pin, // analog power-up complete
	input wire logic pll_lock_pin, // analog pll lock
	input wire logic rx_term_timeout, // rx termination timeout
	input wire logic rx_bad_len, // bad packet length
	input wire logic rx_bad_addr, // bad packet address
	input wire logic rx_bad_crc, // bad packet crc
	input wire logic rx_good_packet, // packet received ok
	input wire logic tx_done, // transmission complete
	input wire logic cal_done, // calibration finished
	input wire logic tx_fifo_write, // byte written to tx fifo
	input wire logic tx_fifo_nonempty, // tx fifo in use
	input wire logic rx_fifo_nonempty, // rx fifo in use
	output logic [2:0] radio_mode_now, // present radio mode
	output logic [2:0] radio_status_detail, // detail code
	output logic powerup_req, // power-up sequencing wanted
	output logic cal_start, // one-cycle calibration start
	output logic cal_for_rx, // calibration target is rx
	output logic cal_periodic, // periodic recalibration
	output logic tx_active, // transmitting
	output logic rx_active, // receiving
	output logic tx_fifo_flush, // one-cycle tx fifo flush
	output logic rx_fifo_flush, // one-cycle rx fifo flush
	output logic digital_core_supply_en, // digital supply on
	output logic xtal_en, // crystal oscillator on
	output logic pll_en // pll on
);
	// configuration registers
	logic pu_sel_reg, pu_sel_next; // powerup_timing_select
	logic [3:0] pu_code_reg, pu_code_next; // powerup_timeout_code
	logic act_term_reg, act_term_next; // rx_timeout_action
	logic act_unlock_reg, act_unlock_next; // rx_unlock_action
	logic act_bad_reg, act_bad_next; // rx_bad_packet_action
	logic act_good_reg, act_good_next; // rx_good_packet_action
	logic [1:0] act_txd_reg, act_txd_next; // tx_done_action
	logic [2:0] ovr_reg, ovr_next; // power override
	// sequencer state
	rmps_state_t state_reg, state_next;
	rmps_after_t after_reg, after_next; // target after calibration
	logic [2:0] mode_reg, mode_next; // present mode
	logic [2:0] info_reg, info_next; // detail code
	logic cal_go_reg, cal_go_next; // calibration start pulse
	logic cal_rx_reg, cal_rx_next; // calibration for rx
	logic cal_per_reg, cal_per_next; // periodic recalibration
	logic txfl_reg, txfl_next; // tx flush pulse
	logic rxfl_reg, rxfl_next; // rx flush pulse
	// outputs from flops
	logic dsup_reg, dsup_next;
	logic xtal_reg, xtal_next;
	logic pll_reg, pll_next;
	logic [7:0] rdata_reg, rdata_next;
	// internal
	logic [1:0] sync_q; // synchronised pins
	logic pwr_done_s; // power-up complete, synchronised
	logic lock_s; // pll lock, synchronised
	logic tmr_start; // start power-up timer
	logic tmr_exp; // power-up timeout reached
	logic wr_pu, wr_act, wr_mode; // register write decodes
	logic [2:0] cmd_mode; // written mode code
	logic bad_any; // any bad packet event
	logic fifo_any; // either fifo holds data
	logic int_req; // internal functions want power

	// asynchronous analog status passes two flops
	rmps_sync #(.W(2)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({pll_lock_pin, pwrup_done_pin}),
		.q(sync_q)
	);
	assign pwr_done_s = sync_q[0];
	assign lock_s = sync_q[1];

	// power-up timeout timer
	rmps_timer u_timer (
		.clk(clk),
		.rst(rst),
		.start(tmr_start),
		.ticks(rmps_pu_ticks(pu_code_reg)),
		.expired(tmr_exp)
	);

	assign wr_pu = reg_wr_en && (reg_addr == ADDR_PWRUP);
	assign wr_act = reg_wr_en && (reg_addr == ADDR_ACTION);
	assign wr_mode = reg_wr_en && (reg_addr == ADDR_MODE);
	assign cmd_mode = reg_wdata[MODE_LSB +: 3];
	assign bad_any = rx_bad_len || rx_bad_addr || rx_bad_crc;
	assign fifo_any = tx_fifo_nonempty || rx_fifo_nonempty;
	assign int_req = (state_reg != S_STOP);

	// configuration register writes
	always_comb begin
		pu_sel_next = pu_sel_reg;
		pu_code_next = pu_code_reg;
		act_term_next = act_term_reg;
		act_unlock_next = act_unlock_reg;
		act_bad_next = act_bad_reg;
		act_good_next = act_good_reg;
		act_txd_next = act_txd_reg;
		ovr_next = ovr_reg;
		if (wr_pu) begin // unused bits dropped
			pu_sel_next = reg_wdata[PU_SEL_BIT];
			pu_code_next = reg_wdata[PU_CODE_LSB +: 4];
		end
		if (wr_act) begin // bits 6 and 2 dropped
			act_term_next = reg_wdata[ACT_TERM_BIT];
			act_unlock_next = reg_wdata[ACT_UNLOCK_BIT];
			act_bad_next = reg_wdata[ACT_BAD_BIT];
			act_good_next = reg_wdata[ACT_GOOD_BIT];
			act_txd_next = reg_wdata[ACT_TXD_LSB +: 2];
		end
		if (wr_mode) begin
			ovr_next = reg_wdata[OVR_LSB +: 3];
		end
		// hardware change wins over a host write in the same cycle
		if (ovr_reg == OVR_FORCE_DX && tx_fifo_write) begin
			ovr_next = OVR_AFTER_TXW;
		end
	end

	// sequencer next state
	always_comb begin
		state_next = state_reg;
		after_next = after_reg;
		mode_next = mode_reg;
		info_next = info_reg;
		cal_go_next = 1'b0;
		cal_rx_next = cal_rx_reg;
		cal_per_next = cal_per_reg;
		txfl_next = 1'b0;
		rxfl_next = 1'b0;
		tmr_start = 1'b0;
		case (state_reg)
			S_PWRUP: begin
				if ((!pu_sel_reg && pwr_done_s) || (tmr_exp && pwr_done_s)) begin
					case (mode_reg)
						MODE_TX: state_next = S_TX;
						MODE_RX: state_next = S_RX;
						default: begin // calibration modes
							state_next = S_CAL;
							cal_go_next = 1'b1;
							cal_per_next = 1'b0;
							cal_rx_next = (mode_reg != MODE_CAL_TX_STOP);
							if (mode_reg == MODE_CAL_TX_STOP) begin
								after_next = AFT_STOP_TX;
							end else if (mode_reg == MODE_CAL_RX_STOP) begin
								after_next = AFT_STOP_RX;
							end else begin
								after_next = AFT_RX;
							end
						end
					endcase
				end else if (tmr_exp) begin // abort pending mode
					state_next = S_STOP;
					mode_next = (mode_reg == MODE_TX || mode_reg == MODE_CAL_TX_STOP)
						? MODE_STOP_TX : MODE_STOP_RX;
					info_next = INFO_PWRUP_TO;
				end
			end
			S_CAL: begin
				if (cal_done) begin
					case (after_reg)
						AFT_STOP_TX: begin
							state_next = S_STOP;
							mode_next = MODE_STOP_TX;
							info_next = INFO_OK;
						end
						AFT_STOP_RX: begin
							state_next = S_STOP;
							mode_next = MODE_STOP_RX;
							info_next = INFO_OK;
						end
						AFT_TX: begin
							state_next = S_TX;
							mode_next = MODE_TX;
						end
						default: begin
							state_next = S_RX;
							mode_next = MODE_RX;
						end
					endcase
				end
			end
			S_RX: begin
				if (!lock_s || rx_term_timeout) begin
					if ((!lock_s && act_unlock_reg) || (lock_s && act_term_reg)) begin
						rxfl_next = 1'b1;
						state_next = S_CAL;
						cal_go_next = 1'b1;
						cal_rx_next = 1'b1;
						cal_per_next = 1'b0;
						after_next = AFT_RX;
						mode_next = MODE_CAL_RX_RX;
					end else begin // error stop
						state_next = S_STOP;
						mode_next = MODE_STOP_RX;
						info_next = !lock_s ? INFO_UNLOCK : INFO_TERM;
					end
				end else if (bad_any) begin
					if (act_bad_reg) begin
						rxfl_next = 1'b1;
					end else begin
						state_next = S_STOP;
						mode_next = MODE_STOP_RX;
						info_next = rx_bad_crc ? INFO_BAD_CRC
							: (rx_bad_addr ? INFO_BAD_ADDR : INFO_BAD_LEN);
					end
				end else if (rx_good_packet) begin
					if (act_good_reg) begin
						state_next = S_CAL;
						cal_go_next = 1'b1;
						cal_rx_next = 1'b1;
						cal_per_next = 1'b1;
						after_next = AFT_RX;
					end else begin
						state_next = S_STOP;
						mode_next = MODE_STOP_RX;
						info_next = INFO_OK;
					end
				end
			end
			S_TX: begin
				if (tx_done) begin
					case (act_txd_reg)
						TXA_STOP: begin
							state_next = S_STOP;
							mode_next = MODE_STOP_TX;
							info_next = INFO_OK;
						end
						TXA_RECAL_TX: begin
							state_next = S_CAL;
							cal_go_next = 1'b1;
							cal_rx_next = 1'b0;
							cal_per_next = 1'b1;
							after_next = AFT_TX;
						end
						TXA_RX: begin
							state_next = S_RX;
							mode_next = MODE_RX;
						end
						default: begin
							state_next = S_CAL;
							cal_go_next = 1'b1;
							cal_rx_next = 1'b1;
							cal_per_next = 1'b0;
							after_next = AFT_RX;
							mode_next = MODE_CAL_RX_RX;
						end
					endcase
				end
			end
			default: ; // stopped, waits for a host command
		endcase
		if (wr_mode) begin // newest host command wins
			txfl_next = !reg_wdata[TXF_BIT];
			rxfl_next = !reg_wdata[RXF_BIT];
			info_next = INFO_OK;
			cal_go_next = 1'b0;
			if (cmd_mode == MODE_STOP_TX || cmd_mode == MODE_STOP_RX) begin
				state_next = S_STOP;
				mode_next = cmd_mode;
			end else begin // power up first, codes 6 and 7 alike
				state_next = S_PWRUP;
				tmr_start = 1'b1;
				mode_next = (cmd_mode > MODE_CAL_RX_RX) ? MODE_CAL_RX_RX : cmd_mode;
			end
		end
	end

	// power enables and read data
	always_comb begin
		dsup_next = int_req;
		xtal_next = int_req;
		pll_next = int_req && (state_reg != S_PWRUP);
		case (ovr_reg)
			3'h1: begin
				dsup_next = 1'b1;
				xtal_next = 1'b1;
			end
			3'h2: dsup_next = int_req || fifo_any;
			3'h3: begin
				dsup_next = int_req || fifo_any;
				xtal_next = int_req || fifo_any;
			end
			3'h4: dsup_next = 1'b1;
			3'h5: begin
				dsup_next = 1'b1;
				xtal_next = int_req || fifo_any;
			end
			3'h6: begin
				dsup_next = 1'b1;
				xtal_next = 1'b1;
			end
			3'h7: begin
				dsup_next = 1'b1;
				xtal_next = 1'b1;
				pll_next = 1'b1;
			end
			default: ; // code 0 keeps internal requests only
		endcase
		case (reg_addr) // unused bits read zero
			ADDR_PWRUP: rdata_next = {3'h0, pu_sel_reg, pu_code_reg};
			ADDR_ACTION: rdata_next = {act_term_reg, 1'b0, act_unlock_reg,
				act_bad_reg, act_good_reg, 1'b0, act_txd_reg};
			ADDR_MODE: rdata_next = {mode_reg, ovr_reg,
				tx_fifo_nonempty, rx_fifo_nonempty};
			default: rdata_next = 8'h00;
		endcase
	end

	// register all state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pu_sel_reg <= 1'b0;
			pu_code_reg <= PU_CODE_RST;
			act_term_reg <= 1'b0;
			act_unlock_reg <= 1'b0;
			act_bad_reg <= 1'b0;
			act_good_reg <= 1'b0;
			act_txd_reg <= TXA_STOP;
			ovr_reg <= OVR_RST;
			state_reg <= S_STOP;
			after_reg <= AFT_STOP_TX;
			mode_reg <= MODE_STOP_TX;
			info_reg <= INFO_OK;
			cal_go_reg <= 1'b0;
			cal_rx_reg <= 1'b0;
			cal_per_reg <= 1'b0;
			txfl_reg <= 1'b0;
			rxfl_reg <= 1'b0;
			dsup_reg <= 1'b0;
			xtal_reg <= 1'b0;
			pll_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			pu_sel_reg <= pu_sel_next;
			pu_code_reg <= pu_code_next;
			act_term_reg <= act_term_next;
			act_unlock_reg <= act_unlock_next;
			act_bad_reg <= act_bad_next;
			act_good_reg <= act_good_next;
			act_txd_reg <= act_txd_next;
			ovr_reg <= ovr_next;
			state_reg <= state_next;
			after_reg <= after_next;
			mode_reg <= mode_next;
			info_reg <= info_next;
			cal_go_reg <= cal_go_next;
			cal_rx_reg <= cal_rx_next;
			cal_per_reg <= cal_per_next;
			txfl_reg <= txfl_next;
			rxfl_reg <= rxfl_next;
			dsup_reg <= dsup_next;
			xtal_reg <= xtal_next;
			pll_reg <= pll_next;
			rdata_reg <= rdata_next;
		end
	end

	// outputs
	assign reg_rdata = rdata_reg;
	assign radio_mode_now = mode_reg;
	assign radio_status_detail = info_reg;
	assign powerup_req = (state_reg == S_PWRUP);
	assign cal_start = cal_go_reg;
	assign cal_for_rx = cal_rx_reg;
	assign cal_periodic = cal_per_reg;
	assign tx_active = (state_reg == S_TX);
	assign rx_active = (state_reg == S_RX);
	assign tx_fifo_flush = txfl_reg;
	assign rx_fifo_flush = rxfl_reg;
	assign digital_core_supply_en = dsup_reg;
	assign xtal_en = xtal_reg;
	assign pll_en = pll_reg;

	// checks on the sequencer
	property p_pu_var;
		@(posedge clk) disable iff (rst)
		(state_reg == S_PWRUP && !pu_sel_reg && pwr_done_s && !wr_mode)
		|=> (state_reg != S_PWRUP);
	endproperty
	a_pu_var: assert property (p_pu_var) else $error("no start");
	property p_pu_fix;
		@(posedge clk) disable iff (rst)
		(state_reg == S_PWRUP && pu_sel_reg && !tmr_exp && !wr_mode)
		|=> (state_reg == S_PWRUP);
	endproperty
	a_pu_fix: assert property (p_pu_fix) else $error("early start");
	property p_pu_abort;
		@(posedge clk) disable iff (rst)
		(state_reg == S_PWRUP && tmr_exp && !pwr_done_s && !wr_mode)
		|=> (state_reg == S_STOP && info_reg == INFO_PWRUP_TO);
	endproperty
	a_pu_abort: assert property (p_pu_abort) else $error("no abort");
	property p_unlock_err;
		@(posedge clk) disable iff (rst)
		(rx_active && !lock_s && !act_unlock_reg && !wr_mode)
		|=> (mode_reg == MODE_STOP_RX && info_reg == INFO_UNLOCK);
	endproperty
	a_unlock_err: assert property (p_unlock_err) else $error("unlock");
	property p_term_recal;
		@(posedge clk) disable iff (rst)
		(rx_active && lock_s && rx_term_timeout && act_term_reg && !wr_mode)
		|=> (rx_fifo_flush && cal_start && cal_for_rx);
	endproperty
	a_term_recal: assert property (p_term_recal) else $error("term");
	property p_tx_rx;
		@(posedge clk) disable iff (rst)
		(tx_active && tx_done && act_txd_reg == TXA_RX && !wr_mode)
		|=> (rx_active && mode_reg == MODE_RX);
	endproperty
	a_tx_rx: assert property (p_tx_rx) else $error("tx action");
	property p_ovr_txw;
		@(posedge clk) disable iff (rst)
		(ovr_reg == OVR_FORCE_DX && tx_fifo_write) |=> (ovr_reg == OVR_AFTER_TXW);
	endproperty
	a_ovr_txw: assert property (p_ovr_txw) else $error("override");
	property p_ovr_off;
		@(posedge clk) disable iff (rst)
		(ovr_reg == 3'h0 && state_reg == S_STOP) |=> !digital_core_supply_en;
	endproperty
	a_ovr_off: assert property (p_ovr_off) else $error("supply on");
	property p_flush;
		@(posedge clk) disable iff (rst)
		(wr_mode && !reg_wdata[TXF_BIT]) |=> tx_fifo_flush ##1 !tx_fifo_flush;
	endproperty
	a_flush: assert property (p_flush) else $error("tx flush");
endmodule : rmps_top

// ---- tb/rmps_far_model.sv ----
// far-side model: analog power-up, pll lock and calibration engine
`timescale 1ns/100ps
module rmps_far_model #(
	parameter int PU_DLY = 40, // cycles to finish power-up
	parameter int CAL_DLY = 20 // cycles per calibration
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset
	input wire logic powerup_req, // power-up wanted
	input wire logic cal_start, // calibration start pulse
	input wire logic hold_pwrup, // bench: power-up never ends
	input wire logic drop_lock, // bench: pll loses lock
	output logic pwrup_done_pin, // power-up complete
	output logic pll_lock_pin, // pll locked
	output logic cal_done // calibration finished pulse
);
	int pu_cnt; // power-up progress
	int cal_cnt; // calibration countdown
	// done only after a real delay, dropped when the request goes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pu_cnt <= 0;
			cal_cnt <= 0;
			cal_done <= 1'b0;
		end else begin
			pu_cnt <= powerup_req ? pu_cnt + 1 : 0;
			cal_done <= (cal_cnt == 1);
			if (cal_start) cal_cnt <= CAL_DLY;
			else if (cal_cnt > 0) cal_cnt <= cal_cnt - 1;
		end
	end
	assign pwrup_done_pin = (pu_cnt >= PU_DLY) && !hold_pwrup;
	assign pll_lock_pin = !drop_lock;
endmodule : rmps_far_model

// ---- tb/rmps_top_tb_top.sv ----
// self-checking bench for the radio mode and power sequencer
`timescale 1ns/100ps
module rmps_top_tb_top;
	import rmps_pkg::*;
	logic clk = 1'b0; // system clock
	logic rst = 1'b1; // reset
	logic wr_en = 1'b0; // write strobe
	logic [7:0] addr = 8'h00; // register offset
	logic [7:0] wdata = 8'h00; // write data
	logic [6:0] ev = 7'h00; // event pulses
	logic txne = 1'b0; // tx fifo in use
	logic rxne = 1'b0; // rx fifo in use
	logic hold = 1'b0; // stall power-up
	logic drop = 1'b0; // lose lock
	logic [7:0] rdata; // read data
	logic [2:0] mode; // present mode
	logic [2:0] info; // detail code
	logic pu_req, cal_st, txf, rxf, dsup, xen, pen, pu_done, lock, cal_dn;
	logic txa, rxa, cal_rx, cal_per; // active flags, calibration kind
	int fails = 0; // mismatches
	int check_count = 0; // comparisons
	int cyc = 0; // cycle counter
	rmps_top u_dut (.clk(clk), .rst(rst), .reg_wr_en(wr_en),
		.reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
		.pwrup_done_pin(pu_done), .pll_lock_pin(lock),
		.rx_term_timeout(ev[0]), .rx_bad_len(ev[1]), .rx_bad_addr(ev[2]),
		.rx_bad_crc(ev[3]), .rx_good_packet(ev[4]), .tx_done(ev[5]),
		.cal_done(cal_dn), .tx_fifo_write(ev[6]),
		.tx_fifo_nonempty(txne), .rx_fifo_nonempty(rxne),
		.radio_mode_now(mode), .radio_status_detail(info),
		.powerup_req(pu_req), .cal_start(cal_st), .cal_for_rx(cal_rx),
		.cal_periodic(cal_per), .tx_active(txa), .rx_active(rxa),
		.tx_fifo_flush(txf), .rx_fifo_flush(rxf),
		.digital_core_supply_en(dsup), .xtal_en(xen), .pll_en(pen));
	rmps_far_model u_far (.clk(clk), .rst(rst), .powerup_req(pu_req),
		.cal_start(cal_st), .hold_pwrup(hold), .drop_lock(drop),
		.pwrup_done_pin(pu_done), .pll_lock_pin(lock), .cal_done(cal_dn));
	// 50 MHz clock
	initial begin
		forever #10 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one-cycle register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	// read lands one edge after the address
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		repeat (2) @(posedge clk);
		#1;
		chk(rdata, exp);
	endtask : rd
	// one-cycle event, looked at after the taking edge
	task automatic pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev[i] <= 1'b0;
		#1;
	endtask : pulse
	// bounded wait for a settled mode outside power-up
	task automatic waitm(input logic [2:0] m, input int lim);
		int n;
		n = 0;
		#1; // let a write on this edge settle first
		while (!(mode === m && pu_req === 1'b0 && txa === (m == MODE_TX)
			&& rxa === (m == MODE_RX)) && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(8'({mode, txa, rxa}), 8'({m, m == MODE_TX, m == MODE_RX}));
	endtask : waitm
	task automatic go_rx();
		wr(ADDR_MODE, 8'h63);
		waitm(MODE_RX, 500);
	endtask : go_rx
	task automatic pwr(input logic [7:0] d, input logic [2:0] e);
		wr(ADDR_MODE, d);
		repeat (4) @(posedge clk);
		#1;
		chk(8'({dsup, xen, pen}), 8'(e));
	endtask : pwr
	task automatic t_regs();
		rd(ADDR_PWRUP, 8'h0A);
		rd(ADDR_ACTION, 8'h00);
		rd(ADDR_MODE, 8'h0C);
		rd(8'h2F, 8'h00);
		wr(ADDR_PWRUP, 8'hFF);
		rd(ADDR_PWRUP, 8'h1F);
		wr(ADDR_ACTION, 8'hFF);
		rd(ADDR_ACTION, 8'hBB);
		wr(ADDR_PWRUP, 8'h00);
	endtask : t_regs
	task automatic t_rx();
		wr(ADDR_ACTION, 8'h80);
		go_rx();
		pulse(0);
		chk(8'({rxf, cal_st, cal_rx}), 8'h07);
		waitm(MODE_RX, 500);
		wr(ADDR_ACTION, 8'h10);
		pulse(3);
		chk(8'({rxf, mode}), 8'h0B);
		wr(ADDR_ACTION, 8'h00);
		pulse(3);
		chk({2'b00, mode, info}, 8'h0F);
		go_rx();
		pulse(0);
		chk({2'b00, mode, info}, 8'h0C);
		go_rx();
		wr(ADDR_ACTION, 8'h08);
		pulse(4);
		chk(8'({cal_st, cal_per, cal_rx}), 8'h07);
		waitm(MODE_RX, 500);
		wr(ADDR_ACTION, 8'h00);
		pulse(4);
		chk({2'b00, mode, info}, 8'h08);
		go_rx();
		@(posedge clk);
		drop <= 1'b1;
		waitm(MODE_STOP_RX, 20);
		chk(8'(info), 8'h02);
		@(posedge clk);
		drop <= 1'b0;
	endtask : t_rx
	task automatic t_tx();
		logic [2:0] exp_m [4] = '{MODE_STOP_TX, MODE_TX, MODE_RX, MODE_RX};
		for (int a = 0; a < 4; a++) begin
			wr(ADDR_ACTION, 8'(a));
			wr(ADDR_MODE, 8'h43);
			waitm(MODE_TX, 500);
			pulse(5);
			chk(8'(cal_st), 8'(a == 1 || a == 3));
			if (a[0]) chk(8'({cal_per, cal_rx}), 8'(a == 1 ? 2 : 1));
			waitm(exp_m[a], 500);
		end
	endtask : t_tx
	// host calibration modes 4, 5 and 6
	task automatic t_cal();
		logic [2:0] exp_m [3] = '{MODE_STOP_TX, MODE_STOP_RX, MODE_RX};
		for (int c = 0; c < 3; c++) begin
			wr(ADDR_MODE, {3'(c + 4), 5'h03});
			waitm(exp_m[c], 500);
			chk(8'(cal_rx), 8'(c != 0));
		end
	endtask : t_cal
	task automatic t_pu();
		@(posedge clk);
		hold <= 1'b1;
		wr(ADDR_MODE, 8'h43);
		repeat (9990) @(posedge clk);
		#1;
		chk(8'(pu_req), 8'h01);
		waitm(MODE_STOP_TX, 30);
		chk(8'(info), 8'h01);
		@(posedge clk);
		hold <= 1'b0;
		wr(ADDR_PWRUP, 8'h10);
		wr(ADDR_MODE, 8'h63);
		repeat (9990) @(posedge clk);
		#1;
		chk(8'(pu_req), 8'h01);
		waitm(MODE_RX, 30);
	endtask : t_pu
	task automatic t_pwr();
		pwr(8'h1F, 3'h7);
		@(posedge clk);
		rxne <= 1'b1;
		pwr(8'h03, 3'h0);
		pwr(8'h0F, 3'h6);
		pwr(8'h0B, 3'h4);
		pwr(8'h07, 3'h6);
		@(posedge clk);
		rxne <= 1'b0;
		pulse(6);
		rd(ADDR_MODE, 8'h0C);
		@(posedge clk);
		txne <= 1'b1;
		wr(ADDR_MODE, 8'h0D);
		#1;
		chk(8'({txf, rxf}), 8'h02);
		rd(ADDR_MODE, 8'h0E);
		wr(ADDR_MODE, 8'h0E);
		#1;
		chk(8'({txf, rxf}), 8'h01);
	endtask : t_pwr
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_rx();
		t_tx();
		t_cal();
		t_pu();
		t_pwr();
		conclude();
	end
endmodule : rmps_top_tb_top
